// ---- logic/annp_defs.svh ----
`ifndef ANNP_DEFS_SVH
`define ANNP_DEFS_SVH

// Register indices; byte address is four times the index
`define ANNP_IDX_PARTNER_BASE  5'h05
`define ANNP_IDX_EXPANSION     5'h06
`define ANNP_IDX_NP_TRANSMIT   5'h07
`define ANNP_IDX_NP_RECEIVE    5'h08
`define ANNP_IDX_PORT_CONFIG   5'h10

// Expansion register fields
`define ANNP_EXP_BASE_PAGE     5
`define ANNP_EXP_PAR_FAULT     4
`define ANNP_EXP_LP_NP_ABLE    3
`define ANNP_EXP_NP_ABLE       2
`define ANNP_EXP_PAGE_RX       1
`define ANNP_EXP_LP_AN_ABLE    0

// Next-page word fields
`define ANNP_NP_MORE           15
`define ANNP_NP_ACK            14
`define ANNP_NP_MSG            13
`define ANNP_NP_ACK2           12
`define ANNP_NP_TOGGLE         11
`define ANNP_NP_CODE_MSB       10

// Port configuration fields
`define ANNP_CFG_ALT_NP        1

// Reset values and the next-page transmit write mask
`define ANNP_NP_TX_RESET       16'h2001
`define ANNP_NP_RX_RESET       16'h0000
`define ANNP_CFG_RESET         16'h0000
`define ANNP_NP_TX_WR_MASK     16'hBFFF

`endif

// ---- logic/annp_pkg.sv ----
package annp_pkg;

  typedef enum logic [1:0] {
    ANNP_IDLE = 2'b01,
    ANNP_ACK  = 2'b10
  } annp_bus_state_t;

endpackage

// ---- logic/annp_regs.sv ----
// Local design decision: the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
`include "annp_defs.svh"

module annp_regs
  import annp_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        an_base_page,
  input  wire logic        an_par_fault,
  input  wire logic        an_lp_np_able,
  input  wire logic        an_lp_an_able,
  input  wire logic        an_page_rx,
  input  wire logic        an_page_is_next,
  input  wire logic [15:0] an_rx_word,
  input  wire logic        an_transmit_disable,
  output logic      [15:0] np_tx_word,
  output logic             alt_next_page_enable,
  output logic      [15:0] partner_base_word
);

  typedef struct packed {
    annp_bus_state_t bus;
    logic [31:0]     rdata;
    logic [1:0]      base_page_s;
    logic [1:0]      par_fault_s;
    logic [1:0]      lp_np_s;
    logic [1:0]      lp_an_s;
    logic [1:0]      page_rx_s;
    logic [1:0]      page_next_s;
    logic [1:0]      tx_dis_s;
    logic            page_rx_prev;
    logic            tx_dis_prev;
    logic            par_fault_lh;
    logic            page_rx_lh;
    logic [15:0]     np_tx;
    logic [15:0]     np_rx;
    logic [15:0]     lp_base;
    logic [15:0]     cfg;
  } annp_state_t;

  annp_state_t s_q;
  annp_state_t s_d;

  // Merge a write into a 16-bit register under the low byte enables
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] wdat,
                                          input logic [3:0]  sel,
                                          input logic [15:0] wmask);
    logic [15:0] v;
    v = old_v;
    if (sel[0]) begin
      v[7:0] = wdat[7:0];
    end
    if (sel[1]) begin
      v[15:8] = wdat[15:8];
    end
    merge16 = (v & wmask) | (old_v & ~wmask);
  endfunction

  logic        req;
  logic [4:0]  idx;
  logic        in_range;
  logic        rx_word_pulse;
  logic [15:0] rx_word;
  logic [15:0] exp_word;
  logic        ext_clear;

  // Word-aligned index; upper address bits must be zero to hit
  assign idx      = wb_adr_i[6:2];
  assign in_range = (wb_adr_i[31:7] == 25'h0000000);
  assign req      = wb_cyc_i & wb_stb_i;

  // The received word is sampled once the page event is stable, so the
  // partner must hold the word steady across the synchroniser delay
  assign rx_word       = an_rx_word;
  assign rx_word_pulse = s_q.page_rx_s[1] & ~s_q.page_rx_prev;

  assign ext_clear = s_q.cfg[`ANNP_CFG_ALT_NP] &
                     ((~s_q.page_rx_s[1] & s_q.page_rx_prev) |
                      (s_q.tx_dis_s[1] & ~s_q.tx_dis_prev));

  always_comb begin
    exp_word = 16'h0000;
    exp_word[`ANNP_EXP_BASE_PAGE]  = s_q.base_page_s[1];
    exp_word[`ANNP_EXP_PAR_FAULT]  = s_q.par_fault_lh;
    exp_word[`ANNP_EXP_LP_NP_ABLE] = s_q.lp_np_s[1];
    exp_word[`ANNP_EXP_NP_ABLE]    = 1'b1;
    exp_word[`ANNP_EXP_PAGE_RX]    = s_q.page_rx_lh;
    exp_word[`ANNP_EXP_LP_AN_ABLE] = s_q.lp_an_s[1];
  end

  always_comb begin
    s_d = s_q;
    s_d.base_page_s = {s_q.base_page_s[0], an_base_page};
    s_d.par_fault_s = {s_q.par_fault_s[0], an_par_fault};
    s_d.lp_np_s     = {s_q.lp_np_s[0], an_lp_np_able};
    s_d.lp_an_s     = {s_q.lp_an_s[0], an_lp_an_able};
    s_d.page_rx_s   = {s_q.page_rx_s[0], an_page_rx};
    s_d.page_next_s = {s_q.page_next_s[0], an_page_is_next};
    s_d.tx_dis_s    = {s_q.tx_dis_s[0], an_transmit_disable};
    s_d.page_rx_prev = s_q.page_rx_s[1];
    s_d.tx_dis_prev  = s_q.tx_dis_s[1];

    unique case (s_q.bus)
      ANNP_IDLE: begin
        if (req) begin
          s_d.bus   = ANNP_ACK;
          s_d.rdata = 32'h00000000;
          if (in_range) begin
            if (wb_we_i) begin
              if (idx == `ANNP_IDX_NP_TRANSMIT) begin
                s_d.np_tx = merge16(s_q.np_tx, wb_dat_i, wb_sel_i,
                                    `ANNP_NP_TX_WR_MASK);
              end
              if (idx == `ANNP_IDX_PORT_CONFIG) begin
                s_d.cfg = merge16(s_q.cfg, wb_dat_i, wb_sel_i,
                                  16'hFFFF);
              end
            end else begin
              unique case (idx)
                `ANNP_IDX_PARTNER_BASE: s_d.rdata[15:0] = s_q.lp_base;
                `ANNP_IDX_EXPANSION: begin
                  s_d.rdata[15:0] = exp_word;
                  // Read clears; a new event this cycle still wins below
                  s_d.par_fault_lh = 1'b0;
                  s_d.page_rx_lh   = 1'b0;
                end
                `ANNP_IDX_NP_TRANSMIT:  s_d.rdata[15:0] = s_q.np_tx;
                `ANNP_IDX_NP_RECEIVE:   s_d.rdata[15:0] = s_q.np_rx;
                `ANNP_IDX_PORT_CONFIG:  s_d.rdata[15:0] = s_q.cfg;
                default:                s_d.rdata = 32'h00000000;
              endcase
            end
          end
        end
      end
      ANNP_ACK: begin
        s_d.bus = ANNP_IDLE;
      end
      default: begin
        s_d.bus = ANNP_IDLE;
      end
    endcase

    if (ext_clear) begin
      s_d.page_rx_lh = 1'b0;
    end

    // Set after clears so a coincident event is never lost
    if (s_q.par_fault_s[1]) begin
      s_d.par_fault_lh = 1'b1;
    end
    if (rx_word_pulse) begin
      if (s_q.page_next_s[1]) begin
        s_d.np_rx = rx_word;
      end else begin
        s_d.lp_base = rx_word;
      end
      s_d.page_rx_lh = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q       <= '0;
      s_q.bus   <= ANNP_IDLE;
      s_q.np_tx <= `ANNP_NP_TX_RESET;
      s_q.np_rx <= `ANNP_NP_RX_RESET;
      s_q.cfg   <= `ANNP_CFG_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_dat_o             = s_q.rdata;
  assign wb_ack_o             = s_q.bus[1];
  assign np_tx_word           = s_q.np_tx;
  assign alt_next_page_enable = s_q.cfg[`ANNP_CFG_ALT_NP];
  assign partner_base_word    = s_q.lp_base;

endmodule
`default_nettype wire

// ---- testbench/annp_partner.sv ----
`timescale 1ns/10ps
`default_nettype none
module annp_partner (
  input wire logic    core_clk,
  output logic        an_page_rx,
  output logic        an_page_is_next,
  output logic [15:0] an_rx_word
);
  initial begin
    an_page_rx = 1'b0;
    an_page_is_next = 1'b0;
    an_rx_word = 16'h0000;
  end
  // Word is sampled unsynced, so it settles well before the strobe
  task automatic send(input logic nxt, input logic [15:0] w);
    @(posedge core_clk);
    an_page_is_next <= nxt;
    an_rx_word <= w;
    repeat (4) @(posedge core_clk);
    an_page_rx <= 1'b1;
    repeat (6) @(posedge core_clk);
    an_page_rx <= 1'b0;
    an_rx_word <= ~w; // Stale word must not be reused
  endtask
endmodule
`default_nettype wire

// ---- testbench/annp_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
module annp_sva (
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic        wb_we_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [15:0] np_tx_word,
  input wire logic        alt_next_page_enable
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic tk;
  logic rd6;
  assign tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rd6 = wb_ack_o && !wb_we_i && wb_adr_i[6:2] == 5'h06;
  ack_in_one_a: assert property (tk |=> wb_ack_o) else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(tk))
    else $error("ack unasked");
  exp_zero_a: assert property (rd6 |-> wb_dat_o[15:6] == 10'h000)
    else $error("reserved bits set");
  np_able_a: assert property (rd6 |-> wb_dat_o[2])
    else $error("next page able low");
  tx_resv_a: assert property (np_tx_word[14] == 1'b0)
    else $error("reserved tx bit set");
  tx_write_a: assert property (tk && wb_we_i && wb_adr_i[6:2] == 5'h07
    && wb_sel_i[1:0] == 2'h3 |=> {16'h0000, np_tx_word}
    == ($past(wb_dat_i) & 32'h0000BFFF)) else $error("tx write lost");
  cfg_hold_a: assert property (!(tk && wb_we_i) |=> $stable(np_tx_word)
    && $stable(alt_next_page_enable)) else $error("register drift");
  cover property (rd6);
  cover property (tk && wb_we_i);
  cover property (alt_next_page_enable);
endmodule
bind annp_regs annp_sva i_annp_sva (.*);
`default_nettype wire

// ---- testbench/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        core_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        wb_we_i = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_ack_o;
  logic        an_transmit_disable = 1'b0;
  logic        an_base_page = 1'b0;
  logic        an_par_fault = 1'b0;
  logic        an_lp_np_able = 1'b0;
  logic        an_lp_an_able = 1'b0;
  logic        an_page_rx;
  logic        an_page_is_next;
  logic        alt_next_page_enable;
  logic [31:0] wb_adr_i = 32'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [15:0] an_rx_word, np_tx_word, partner_base_word, r, w;
  int          errors = 0, tests_run = 0, cyc_cnt = 0, seed = 4, i;
  annp_regs i_annp_regs (.*);
  annp_partner i_annp_partner (.*);
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 3000) begin
      errors++;
      tally_and_finish();
    end
  end
  task tally_and_finish();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wb(input logic we, input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {24'h0, a};
    wb_dat_i <= {16'h0, d};
    do @(posedge core_clk); while (wb_ack_o !== 1'b1);
    r = wb_dat_o[15:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [15:0] e);
    wb(1'b0, a, 16'h0000);
    chk(r, e);
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    rd(8'h1C, 16'h2001);
    rd(8'h20, 16'h0000);
    rd(8'h40, 16'h0000);
    rd(8'h18, 16'h0004);
    rd(8'h0C, 16'h0000);
    $display("reset test done");
    for (i = 0; i < 4; i++) begin
      w = $random(seed);
      wb(1'b1, 8'h1C, w);
      rd(8'h1C, w & 16'hBFFF);
    end
    wb(1'b1, 8'h20, w);
    rd(8'h20, 16'h0000);
    $display("transmit test done");
    for (i = 0; i < 8; i++) begin
      {an_base_page, an_lp_np_able, an_lp_an_able} <= i[2:0];
      repeat (4) @(posedge core_clk);
      rd(8'h18, {10'h0, i[2], 1'b0, i[1], 2'b10, i[0]});
    end
    an_par_fault <= 1'b1;
    repeat (4) @(posedge core_clk);
    an_par_fault <= 1'b0;
    repeat (4) @(posedge core_clk);
    rd(8'h18, 16'h003D);
    rd(8'h18, 16'h002D);
    $display("status test done");
    w = $random(seed);
    i_annp_partner.send(1'b1, w);
    repeat (4) @(posedge core_clk);
    rd(8'h20, w);
    rd(8'h18, 16'h002F);
    rd(8'h18, 16'h002D);
    w = $random(seed);
    i_annp_partner.send(1'b0, w);
    repeat (4) @(posedge core_clk);
    chk(partner_base_word, w);
    rd(8'h14, w);
    rd(8'h18, 16'h002F);
    $display("page test done");
    wb(1'b1, 8'h40, 16'h0002);
    chk({15'h0, alt_next_page_enable}, 16'h0001);
    i_annp_partner.send(1'b1, w);
    repeat (4) @(posedge core_clk);
    rd(8'h18, 16'h002D);
    fork
      i_annp_partner.send(1'b1, w);
      begin
        repeat (8) @(posedge core_clk);
        an_transmit_disable <= 1'b1;
        repeat (2) @(posedge core_clk);
        rd(8'h18, 16'h002D);
      end
    join
    an_transmit_disable <= 1'b0;
    repeat (4) @(posedge core_clk);
    $display("alternate test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
